// ==== rtl/engine_fault_supervisor.sv ====
// Purpose: Print engine fault supervisor raising latched service faults
// Assumes: Comparator results and strobes arrive synchronous to clk
// Notes:   All durations run on a 1 ms tick from a clock divider
`timescale 1ns/1ps
`default_nettype none
module engine_fault_supervisor import fault_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Sensor and actuator state
  input  wire density_in_s       dens,
  input  wire process_in_s       proc_in,
  input  wire motor_in_s         mot,
  input  wire tray_in_s          tray,
  // Fault clear from controller
  input  wire logic              clear_valid,
  input  wire logic [CODE_W-1:0] clear_code,
  // Density sensor drive
  output logic      [7:0]        duty_out_r,
  // Fault report
  output logic [NUM_FAULTS-1:0]  fault_pending,
  output logic                   fault_event,
  output logic      [CODE_W-1:0] fault_code
);

  if (TICK_CYC < 2) begin : g_chk
    $error("engine_fault_supervisor: TICK_CYC must be at least 2");
  end

  localparam int DIV_W = $clog2(TICK_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic             tick_r;
  logic             tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = div_r + DIV_W'(1);
    if (div_r == DIV_W'(TICK_CYC - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duration timers
  logic [NUM_TIMERS-1:0] tcond;
  logic [NUM_TIMERS-1:0] trestart;
  logic [NUM_TIMERS-1:0] tfire;
  logic [TIMER_W-1:0]    tlim [NUM_TIMERS];
  logic                  suct_prev_r;

  always_comb begin
    trestart = '0;
    tcond[T_DRUM_LOCK] = mot.drum_motor_on & mot.drum_lock;
    tlim[T_DRUM_LOCK]  = DRUM_LOCK_T;
    tcond[T_DEV_LOCK]  = mot.dev_motor_on & ~mot.dev_lock;
    tlim[T_DEV_LOCK]   = DEV_LOCK_T;
    tcond[T_FAN_LOCK]  = mot.fan_on & mot.fan_lock;
    tlim[T_FAN_LOCK]   = FAN_LOCK_T;
    tcond[T_SUCTION]   = mot.suction_motor_on;
    trestart[T_SUCTION] = mot.suction_lock_sense ^ suct_prev_r;
    tlim[T_SUCTION]    = SUCTION_MOT_T;
    tcond[T_WASTE_SET] = ~mot.waste_bottle_set;
    tlim[T_WASTE_SET]  = BOTTLE_T;
    tcond[T_SUCT_SET]  = ~mot.suction_bottle_set;
    tlim[T_SUCT_SET]   = BOTTLE_T;
    tcond[T_SUCT_OPER] = mot.machine_operating &
                         ~mot.suction_bottle_set;
    tlim[T_SUCT_OPER]  = BOTTLE_T;
    tcond[T_DENS_ADJ]  = dens.bare_check_active &
                         ~dens.bare_in_window;
    tlim[T_DENS_ADJ]   = DENS_ADJ_T;
    for (int t = 0; t < NUM_TRAYS; t++) begin
      tcond[T_TRAY_SENS + t]  = tray.lift_motor_on[t] &
                                ~tray.lift_sensor[t];
      tcond[T_TRAY_UPPER + t] = tray.feed_lifting[t] &
                                ~tray.upper_limit[t];
      // Last tray is the deepest stack and lifts slowest
      tlim[T_TRAY_SENS + t]   = (t == NUM_TRAYS - 1) ?
                                TRAY6_LIFT_T : TRAY_LIFT_T;
      tlim[T_TRAY_UPPER + t]  = tlim[T_TRAY_SENS + t];
    end
  end

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    logic [TIMER_W-1:0] cnt_r;
    logic [TIMER_W-1:0] cnt_nxt;
    logic               fire;

    always_comb begin
      cnt_nxt = cnt_r;
      fire    = 1'b0;
      if (!tcond[i] || trestart[i]) begin
        cnt_nxt = '0;
      end else if (tick_r && (cnt_r < tlim[i])) begin
        cnt_nxt = cnt_r + TIMER_W'(1);
        // Saturates so a held condition raises only once
        fire    = (cnt_nxt == tlim[i]);
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end

    assign tfire[i] = fire;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample counters, toner window and density drive
  logic [3:0]         pot_cnt_r;
  logic [3:0]         pot_cnt_nxt;
  logic [4:0]         leak_cnt_r;
  logic [4:0]         leak_cnt_nxt;
  logic [3:0]         clutch_cnt_r;
  logic [3:0]         clutch_cnt_nxt;
  logic [TIMER_W-1:0] twin_r;
  logic [TIMER_W-1:0] twin_nxt;
  logic               clutch_prev_r;
  logic [7:0]         duty_nxt;
  logic               pot_fire;
  logic               leak_fire;
  logic               toner_fire;
  logic               cal_fire;
  logic               leak_armed;
  logic               toner_armed;

  always_comb begin
    pot_cnt_nxt    = pot_cnt_r;
    leak_cnt_nxt   = leak_cnt_r;
    clutch_cnt_nxt = clutch_cnt_r;
    twin_nxt       = twin_r;
    duty_nxt       = duty_out_r;
    pot_fire       = 1'b0;
    leak_fire      = 1'b0;
    toner_fire     = 1'b0;
    cal_fire       = 1'b0;

    // Only an applied code changes the drive; calibration end leaves it
    if (dens.duty_apply) begin
      duty_nxt = dens.duty_code;
    end
    if (dens.init_active && dens.cal_sample) begin
      if (duty_out_r == DUTY_MAX && dens.below_4v) begin
        cal_fire = 1'b1;
      end
      if (duty_out_r == DUTY_MIN && !dens.below_4v) begin
        cal_fire = 1'b1;
      end
    end

    if (proc_in.drum_pot_sample) begin
      if (!proc_in.drum_pot_over_800v) begin
        pot_cnt_nxt = '0;
      end else if (pot_cnt_r < DRUM_POT_CNT) begin
        pot_cnt_nxt = pot_cnt_r + 4'h0001;
        pot_fire    = (pot_cnt_nxt == DRUM_POT_CNT);
      end
    end

    leak_armed = proc_in.xfer_active & proc_in.xfer_over_setting;
    if (!leak_armed) begin
      leak_cnt_nxt = '0;
    end else if (proc_in.xfer_fb_sample) begin
      if (!proc_in.xfer_fb_below_075v) begin
        leak_cnt_nxt = '0;
      end else if (leak_cnt_r < XFER_LEAK_CNT) begin
        leak_cnt_nxt = leak_cnt_r + 5'h0001;
        leak_fire    = (leak_cnt_nxt == XFER_LEAK_CNT);
      end
    end

    // Window opens on the first clutch pulse and closes after 2 s
    toner_armed = mot.toner_supply_active & mot.hopper_no_toner;
    if (!toner_armed) begin
      clutch_cnt_nxt = '0;
      twin_nxt       = '0;
    end else begin
      if (clutch_cnt_r != 4'h0000 && tick_r) begin
        twin_nxt = twin_r + TIMER_W'(1);
      end
      if (twin_nxt >= TONER_WIN_T) begin
        clutch_cnt_nxt = '0;
        twin_nxt       = '0;
      end else if (mot.coil_clutch_on && !clutch_prev_r &&
                   clutch_cnt_r < TONER_CLUTCH_CNT) begin
        clutch_cnt_nxt = clutch_cnt_r + 4'h0001;
        toner_fire     = (clutch_cnt_nxt == TONER_CLUTCH_CNT);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pot_cnt_r     <= '0;
      leak_cnt_r    <= '0;
      clutch_cnt_r  <= '0;
      twin_r        <= '0;
      clutch_prev_r <= 1'b0;
      suct_prev_r   <= 1'b0;
      duty_out_r    <= DUTY_RESET;
    end else begin
      pot_cnt_r     <= pot_cnt_nxt;
      leak_cnt_r    <= leak_cnt_nxt;
      clutch_cnt_r  <= clutch_cnt_nxt;
      twin_r        <= twin_nxt;
      clutch_prev_r <= mot.coil_clutch_on;
      suct_prev_r   <= mot.suction_lock_sense;
      duty_out_r    <= duty_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault raise vector
  logic [NUM_FAULTS-1:0] raise;

  always_comb begin
    raise                  = '0;
    raise[F_DENS_CAL]      = cal_fire;
    raise[F_DENS_ADJ]      = tfire[T_DENS_ADJ];
    raise[F_DRUM_POT]      = pot_fire;
    raise[F_XFER_LEAK]     = leak_fire;
    raise[F_QUENCH]        = proc_in.pc_init_done &
                             ~mot.drum_motor_on &
                             proc_in.drum_pot_out_of_range;
    raise[F_DRUM_LOCK]     = tfire[T_DRUM_LOCK];
    raise[F_DEV_LOCK]      = tfire[T_DEV_LOCK];
    raise[F_FAN_LOCK]      = tfire[T_FAN_LOCK];
    raise[F_SUCTION_MOTOR] = tfire[T_SUCTION];
    raise[F_TONER_BOTTLE]  = toner_fire;
    raise[F_COLLECTION]    = tfire[T_WASTE_SET] | tfire[T_SUCT_SET];
    raise[F_SUCTION_BTL]   = tfire[T_SUCT_OPER];
    for (int t = 0; t < NUM_TRAYS; t++) begin
      raise[F_TRAY_LIFT + t] = tfire[T_TRAY_SENS + t] |
                               tfire[T_TRAY_UPPER + t] |
                               (tray.inserted[t] &
                                tray.lift_sensor[t]);
    end
  end

  fault_code_store #(
    .N (NUM_FAULTS)
  ) u_store (
    .clk          (clk),
    .resetn       (resetn),
    .raise        (raise),
    .clear_valid  (clear_valid),
    .clear_code   (clear_code),
    .pending_r    (fault_pending),
    .event_r      (fault_event),
    .event_code_r (fault_code)
  );

endmodule
`default_nettype wire

// ==== rtl/fault_pkg.sv ====
// Purpose: Shared constants and carriers for the engine fault supervisor
// Assumes: 40 MHz system clock, all sensor inputs synchronous to it
// Notes:   Times are held in ms; tick counts derive from the ms tick
package fault_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TIMER_W     = 15;

  // Durations as printed, in ms
  localparam int DRUM_LOCK_MS   = 2000;
  localparam int DEV_LOCK_MS    = 2000;
  localparam int FAN_LOCK_MS    = 5000;
  localparam int SUCTION_MOT_MS = 1000;
  localparam int BOTTLE_MS      = 3000;
  localparam int DENS_ADJ_MS    = 20000;
  localparam int TONER_WIN_MS   = 2000;
  localparam int TRAY_LIFT_MS   = 10000;
  localparam int TRAY6_LIFT_MS  = 20000;

  // Durations in ms ticks
  localparam logic [TIMER_W-1:0] DRUM_LOCK_T   =
    TIMER_W'(DRUM_LOCK_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] DEV_LOCK_T    =
    TIMER_W'(DEV_LOCK_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] FAN_LOCK_T    =
    TIMER_W'(FAN_LOCK_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] SUCTION_MOT_T =
    TIMER_W'(SUCTION_MOT_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] BOTTLE_T      =
    TIMER_W'(BOTTLE_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] DENS_ADJ_T    =
    TIMER_W'(DENS_ADJ_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] TONER_WIN_T   =
    TIMER_W'(TONER_WIN_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] TRAY_LIFT_T   =
    TIMER_W'(TRAY_LIFT_MS / TICK_MS);
  localparam logic [TIMER_W-1:0] TRAY6_LIFT_T  =
    TIMER_W'(TRAY6_LIFT_MS / TICK_MS);

  ////////////////////////////////////////////////////////////////////////////
  // Sample counts and duty codes
  localparam logic [7:0] DUTY_MAX      = 8'h00FF;
  localparam logic [7:0] DUTY_MIN      = 8'h0000;
  localparam logic [7:0] DUTY_RESET    = 8'h0080;
  localparam logic [3:0] DRUM_POT_CNT  = 4'h000A;
  localparam logic [4:0] XFER_LEAK_CNT = 5'h0010;
  localparam logic [3:0] TONER_CLUTCH_CNT = 4'h000A;

  ////////////////////////////////////////////////////////////////////////////
  // Fault codes: index into the pending vector
  localparam int NUM_TRAYS       = 6;
  localparam int NUM_FAULTS      = 18;
  localparam int CODE_W          = 5;
  localparam int F_DENS_CAL      = 0;
  localparam int F_DENS_ADJ      = 1;
  localparam int F_DRUM_POT      = 2;
  localparam int F_XFER_LEAK     = 3;
  localparam int F_QUENCH        = 4;
  localparam int F_DRUM_LOCK     = 5;
  localparam int F_DEV_LOCK      = 6;
  localparam int F_FAN_LOCK      = 7;
  localparam int F_SUCTION_MOTOR = 8;
  localparam int F_TONER_BOTTLE  = 9;
  localparam int F_COLLECTION    = 10;
  localparam int F_SUCTION_BTL   = 11;
  localparam int F_TRAY_LIFT     = 12;

  // Duration timer slots
  localparam int NUM_TIMERS   = 20;
  localparam int T_DRUM_LOCK  = 0;
  localparam int T_DEV_LOCK   = 1;
  localparam int T_FAN_LOCK   = 2;
  localparam int T_SUCTION    = 3;
  localparam int T_WASTE_SET  = 4;
  localparam int T_SUCT_SET   = 5;
  localparam int T_SUCT_OPER  = 6;
  localparam int T_DENS_ADJ   = 7;
  localparam int T_TRAY_SENS  = 8;
  localparam int T_TRAY_UPPER = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       init_active;
    logic       cal_sample;
    logic       below_4v;
    logic       duty_apply;
    logic [7:0] duty_code;
    logic       bare_check_active;
    logic       bare_in_window;
  } density_in_s;

  typedef struct packed {
    logic drum_pot_sample;
    logic drum_pot_over_800v;
    logic xfer_active;
    logic xfer_over_setting;
    logic xfer_fb_sample;
    logic xfer_fb_below_075v;
    logic pc_init_done;
    logic drum_pot_out_of_range;
  } process_in_s;

  typedef struct packed {
    logic drum_motor_on;
    logic drum_lock;
    logic dev_motor_on;
    logic dev_lock;
    logic fan_on;
    logic fan_lock;
    logic suction_motor_on;
    logic suction_lock_sense;
    logic toner_supply_active;
    logic coil_clutch_on;
    logic hopper_no_toner;
    logic waste_bottle_set;
    logic suction_bottle_set;
    logic machine_operating;
  } motor_in_s;

  typedef struct packed {
    logic [NUM_TRAYS-1:0] lift_motor_on;
    logic [NUM_TRAYS-1:0] lift_sensor;
    logic [NUM_TRAYS-1:0] feed_lifting;
    logic [NUM_TRAYS-1:0] upper_limit;
    logic [NUM_TRAYS-1:0] inserted;
  } tray_in_s;

endpackage

// ==== rtl/fault_code_store.sv ====
// Purpose: Latches raised faults as pending flags and reports each event
// Assumes: One raise vector per cycle, one clear request per cycle
// Notes:   A raise in the same cycle as its clear keeps the flag set
`timescale 1ns/1ps
`default_nettype none
module fault_code_store import fault_pkg::*; #(
  parameter int N = NUM_FAULTS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Raise and clear
  input  wire logic [N-1:0]      raise,
  input  wire logic              clear_valid,
  input  wire logic [CODE_W-1:0] clear_code,
  // Report
  output logic      [N-1:0]      pending_r,
  output logic                   event_r,
  output logic      [CODE_W-1:0] event_code_r
);

  if (N > (1 << CODE_W)) begin : g_chk
    $error("fault_code_store: too many codes for CODE_W");
  end

  logic [N-1:0]      pending_nxt;
  logic              event_nxt;
  logic [CODE_W-1:0] event_code_nxt;

  always_comb begin
    pending_nxt    = pending_r;
    event_nxt      = |raise;
    event_code_nxt = event_code_r;
    if (clear_valid && (32'(clear_code) < N)) begin
      pending_nxt[clear_code] = 1'b0;
    end
    // Set after clear so a simultaneous raise wins
    pending_nxt = pending_nxt | raise;
    // Lowest index wins when several rise together
    for (int i = N - 1; i >= 0; i--) begin
      if (raise[i]) begin
        event_code_nxt = CODE_W'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_r    <= '0;
      event_r      <= 1'b0;
      event_code_r <= '0;
    end else begin
      pending_r    <= pending_nxt;
      event_r      <= event_nxt;
      event_code_r <= event_code_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/fault_monitor.sv ====
// Purpose: Port-level checks on the engine fault supervisor
// Assumes: Single clock domain, async active-low reset
// Notes:   Drum lock timing judged by a cycle counter of helper logic
`timescale 1ns/1ps
`default_nettype none
module fault_monitor import fault_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Inputs seen
  input wire density_in_s           dens,
  input wire process_in_s           proc_in,
  input wire motor_in_s             mot,
  input wire tray_in_s              tray,
  input wire logic                  clear_valid,
  input wire logic [CODE_W-1:0]     clear_code,
  // Outputs seen
  input wire logic [7:0]            duty_out_r,
  input wire logic [NUM_FAULTS-1:0] fault_pending,
  input wire logic                  fault_event,
  input wire logic [CODE_W-1:0]     fault_code
);
  // Tick phase allows one ms of slack each way
  localparam int EARLY_C = (DRUM_LOCK_MS - 1) * TICK_CYC;
  localparam int LATE_C  = (DRUM_LOCK_MS + 1) * TICK_CYC + 3;
  int drum_cnt_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drum_cnt_r <= 0;
    end else if (!(mot.drum_motor_on && mot.drum_lock)) begin
      drum_cnt_r <= 0;
    end else if (drum_cnt_r <= LATE_C) begin
      drum_cnt_r <= drum_cnt_r + 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  chk_cal_max_fault: assert property (dens.init_active && dens.cal_sample &&
    dens.below_4v && duty_out_r == 8'h00FF |=> fault_pending[F_DENS_CAL])
    else $error("max duty low reading not flagged");
  chk_cal_min_fault: assert property (dens.init_active && dens.cal_sample &&
    !dens.below_4v && duty_out_r == 8'h0000 |=> fault_pending[F_DENS_CAL])
    else $error("min duty high reading not flagged");
  chk_duty_load: assert property (dens.duty_apply |=>
    duty_out_r == $past(dens.duty_code)) else $error("duty not loaded");
  chk_duty_hold: assert property (!dens.duty_apply |=> $stable(duty_out_r))
    else $error("duty changed without apply");
  chk_quench_fault: assert property (proc_in.pc_init_done &&
    !mot.drum_motor_on && proc_in.drum_pot_out_of_range |=>
    fault_pending[F_QUENCH]) else $error("quench fault missing");
  chk_insert_fault: assert property ((tray.inserted & tray.lift_sensor) != 0
    |=> (fault_pending[17:12] & $past(tray.inserted & tray.lift_sensor)) ==
    $past(tray.inserted & tray.lift_sensor)) else $error("insert fault");
  chk_pending_sticky: assert property (!clear_valid |=>
    (fault_pending & $past(fault_pending)) == $past(fault_pending))
    else $error("pending flag lost without clear");
  chk_event_on_rise: assert property (
    (fault_pending & ~$past(fault_pending)) != 0 |-> fault_event)
    else $error("new fault without event");
  chk_event_code: assert property (fault_event |->
    fault_pending[fault_code]) else $error("event code not pending");
  chk_drum_early: assert property ($rose(fault_pending[F_DRUM_LOCK]) |->
    drum_cnt_r >= EARLY_C) else $error("drum lock fault too early");
  chk_drum_late: assert property (drum_cnt_r == LATE_C |->
    fault_pending[F_DRUM_LOCK]) else $error("drum lock fault too late");

  cov_cal: cover property (dens.cal_sample && dens.init_active);
  cov_event: cover property (fault_event);
  cov_insert: cover property ((tray.inserted & tray.lift_sensor) != 0);
endmodule
bind engine_fault_supervisor fault_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
  .clk(clk), .resetn(resetn), .dens(dens), .proc_in(proc_in), .mot(mot),
  .tray(tray), .clear_valid(clear_valid), .clear_code(clear_code),
  .duty_out_r(duty_out_r), .fault_pending(fault_pending),
  .fault_event(fault_event), .fault_code(fault_code));
`default_nettype wire

// ==== testbench/motor_partner.sv ====
// Purpose: Suction motor lock sense and toner coil clutch behaviour
// Assumes: Lock sense toggles while the motor turns freely
// Notes:   Clutch pulses only while supply runs, low otherwise
`timescale 1ns/1ps
`default_nettype none
module motor_partner #(
  parameter int HALF = 100
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Control from bench
  input  wire logic suction_on,
  input  wire logic suction_stuck,
  input  wire logic clutch_run,
  // Sensor outputs
  output logic      sense,
  output logic      clutch
);
  int cnt_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r  <= 0;
      sense  <= 1'b0;
      clutch <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HALF - 1) begin
        // Stuck rotor freezes the sense level
        sense  <= (suction_on && !suction_stuck) ? ~sense : sense;
        clutch <= clutch_run ? ~clutch : 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the engine fault supervisor
// Assumes: Short ms tick so the long limits fit the run
// Notes:   Faults are cleared and inputs idled between scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench import fault_pkg::*;;
  localparam int T = 2;
  logic              clk, resetn, clear_valid, stuck, clutch_run;
  logic              sense, clutch, clutch_q, fault_event;
  logic [CODE_W-1:0] clear_code, fault_code;
  logic [7:0]        duty_out_r;
  logic [17:0]       fault_pending;
  density_in_s       dens;
  process_in_s       proc_in;
  motor_in_s         mot_b, mot_w;
  tray_in_s          tray;
  int                miscompares, samples_checked, cyc, edges;
  int                rise_at [NUM_FAULTS];

  engine_fault_supervisor #(.TICK_CYC(T)) u_dut (.clk(clk),
    .resetn(resetn), .dens(dens), .proc_in(proc_in), .mot(mot_w),
    .tray(tray), .clear_valid(clear_valid), .clear_code(clear_code),
    .duty_out_r(duty_out_r), .fault_pending(fault_pending),
    .fault_event(fault_event), .fault_code(fault_code));
  motor_partner u_partner (.clk(clk), .resetn(resetn),
    .suction_on(mot_b.suction_motor_on), .suction_stuck(stuck),
    .clutch_run(clutch_run), .sense(sense), .clutch(clutch));

  always_comb begin
    mot_w = mot_b;
    mot_w.suction_lock_sense = sense;
    mot_w.coil_clutch_on = clutch;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Records when each flag first shows, and clutch edges seen
  always @(posedge clk) begin
    cyc <= cyc + 1;
    clutch_q <= clutch;
    if (clutch === 1'b1 && clutch_q === 1'b0) edges <= edges + 1;
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (fault_pending[i] === 1'b1 && rise_at[i] < 0) rise_at[i] <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for a flag, then judge its arrival time
  task automatic wait_pend(input int idx, input int t0, input int ms,
                           input int slack);
    int n;
    int d;
    n = 0;
    while (fault_pending[idx] !== 1'b1 && n < (ms + 2) * T + slack) begin
      @(posedge clk);
      n++;
    end
    check("pending", fault_pending[idx], 1'b1);
    if (fault_pending[idx] !== 1'b1) finish_test();
    @(posedge clk);
    d = rise_at[idx] - t0;
    check("delay", d >= ms * T - slack - 2 && d <= (ms + 1) * T + 4, 1'b1);
  endtask
  task automatic expect_soon(input int idx);
    repeat (4) @(posedge clk);
    check("pending", fault_pending[idx], 1'b1);
  endtask
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge clk);
      case (which)
        0: proc_in.drum_pot_sample <= 1'b1;
        1: proc_in.xfer_fb_sample <= 1'b1;
        2: dens.cal_sample <= 1'b1;
        default: proc_in.pc_init_done <= 1'b1;
      endcase
      @(posedge clk);
      {proc_in.drum_pot_sample, proc_in.xfer_fb_sample} <= 2'b00;
      {dens.cal_sample, proc_in.pc_init_done} <= 2'b00;
    end
  endtask
  task automatic clr(input int idx);
    @(posedge clk);
    clear_valid <= 1'b1;
    clear_code <= CODE_W'(idx);
    if (idx < NUM_FAULTS) rise_at[idx] = -1;
    @(posedge clk);
    clear_valid <= 1'b0;
    cycles(2);
  endtask
  task automatic apply_duty(input logic [7:0] code, input logic below);
    @(posedge clk);
    dens.duty_apply <= 1'b1;
    dens.duty_code <= code;
    dens.below_4v <= below;
    @(posedge clk);
    dens.duty_apply <= 1'b0;
    pulse(2, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_cal();
    dens.init_active <= 1'b1;
    apply_duty(8'h00FF, 1'b1);
    expect_soon(F_DENS_CAL);
    clr(5'h001F);
    check("pend kept", fault_pending[F_DENS_CAL], 1'b1);
    clr(F_DENS_CAL);
    check("pend clr", fault_pending[F_DENS_CAL], 1'b0);
    apply_duty(8'h0000, 1'b0);
    expect_soon(F_DENS_CAL);
    clr(F_DENS_CAL);
    apply_duty(8'h0037, 1'b1);
    dens.init_active <= 1'b0;
    cycles(3);
    check("mid duty", fault_pending[F_DENS_CAL], 1'b0);
    check("duty kept", duty_out_r, 8'h0037);
  endtask
  task automatic test_counts();
    proc_in.drum_pot_over_800v <= 1'b1;
    pulse(0, 9);
    proc_in.drum_pot_over_800v <= 1'b0;
    pulse(0, 1);
    proc_in.drum_pot_over_800v <= 1'b1;
    pulse(0, 9);
    cycles(3);
    check("pot early", fault_pending[F_DRUM_POT], 1'b0);
    pulse(0, 1);
    expect_soon(F_DRUM_POT);
    check("code", fault_code, 5'h0002);
    proc_in <= '0;
    {proc_in.xfer_active, proc_in.xfer_over_setting} <= 2'b11;
    proc_in.xfer_fb_below_075v <= 1'b1;
    pulse(1, 15);
    cycles(3);
    check("leak early", fault_pending[F_XFER_LEAK], 1'b0);
    pulse(1, 1);
    expect_soon(F_XFER_LEAK);
    proc_in <= '0;
    clr(F_DRUM_POT);
    clr(F_XFER_LEAK);
  endtask
  task automatic test_quench();
    proc_in.drum_pot_out_of_range <= 1'b1;
    mot_b.drum_motor_on <= 1'b1;
    pulse(3, 1);
    cycles(3);
    check("quench run", fault_pending[F_QUENCH], 1'b0);
    mot_b.drum_motor_on <= 1'b0;
    pulse(3, 1);
    expect_soon(F_QUENCH);
    proc_in <= '0;
    clr(F_QUENCH);
  endtask
  task automatic test_locks();
    int t0;
    int t1;
    int t2;
    // Drum, dev, fan locked; suction running; both bottles out; operating
    mot_b <= 14'b11101110000001;
    t0 = cyc;
    cycles(1000 * T);
    mot_b.drum_lock <= 1'b0;
    cycles(1);
    mot_b.drum_lock <= 1'b1;
    t1 = cyc;
    cycles(500 * T);
    check("suction ok", fault_pending[F_SUCTION_MOTOR], 1'b0);
    stuck <= 1'b1;
    t2 = cyc;
    wait_pend(F_DEV_LOCK, t0, DEV_LOCK_MS, 2);
    wait_pend(F_SUCTION_MOTOR, t2, SUCTION_MOT_MS, 200);
    wait_pend(F_DRUM_LOCK, t1, DRUM_LOCK_MS, 2);
    wait_pend(F_COLLECTION, t0, BOTTLE_MS, 2);
    wait_pend(F_SUCTION_BTL, t0, BOTTLE_MS, 2);
    wait_pend(F_FAN_LOCK, t0, FAN_LOCK_MS, 2);
    mot_b <= 14'b00000000000110;
    stuck <= 1'b0;
    for (int i = F_DRUM_LOCK; i <= F_SUCTION_BTL; i++) clr(i);
    check("all clear", fault_pending, 18'h0_0000);
  endtask
  task automatic test_toner();
    {mot_b.toner_supply_active, mot_b.hopper_no_toner} <= 2'b11;
    clutch_run <= 1'b1;
    edges = 0;
    wait_pend(F_TONER_BOTTLE, cyc, 1902 / T, 100);
    check("clutch edges", edges, 10);
    {mot_b.toner_supply_active, mot_b.hopper_no_toner} <= 2'b00;
    clutch_run <= 1'b0;
    clr(F_TONER_BOTTLE);
  endtask
  task automatic test_trays();
    int t0;
    tray.lift_motor_on <= 6'b100001;
    tray.feed_lifting <= 6'b000010;
    dens.bare_check_active <= 1'b1;
    t0 = cyc;
    wait_pend(12, t0, TRAY_LIFT_MS, 2);
    wait_pend(13, t0, TRAY_LIFT_MS, 2);
    check("tray6 late", fault_pending[17], 1'b0);
    wait_pend(17, t0, TRAY6_LIFT_MS, 2);
    wait_pend(F_DENS_ADJ, t0, DENS_ADJ_MS, 2);
    tray <= '0;
    dens.bare_check_active <= 1'b0;
    clr(12);
    clr(13);
    clr(17);
    clr(F_DENS_ADJ);
    tray.lift_sensor <= 6'b000100;
    @(posedge clk);
    tray.inserted <= 6'b001100;
    @(posedge clk);
    tray.inserted <= '0;
    expect_soon(14);
    check("tray flags", fault_pending[17:12], 6'b000100);
  endtask

  initial begin
    {resetn, clear_valid, stuck, clutch_run, clutch_q} = '0;
    {dens, proc_in, tray, clear_code} = '0;
    mot_b = 14'b00000000000110;
    {miscompares, samples_checked, cyc, edges} = '0;
    foreach (rise_at[i]) rise_at[i] = -1;
    cycles(4);
    resetn <= 1'b1;
    cycles(2);
    check("duty reset", duty_out_r, 8'h0080);
    check("pend reset", fault_pending, 18'h0_0000);
    test_cal();
    test_counts();
    test_quench();
    test_locks();
    test_toner();
    test_trays();
    finish_test();
  end
endmodule
`default_nettype wire
